// ---- src/async_serial_receiver.sv ----
// Asynchronous serial receive path with oversampled start/data/stop recovery
//
// Contract
// [R1] Oversample line at sixteen times baud rate
// [R2] Assembled character moves into two-entry FIFO
// [R3] Receive only with enables set, sync clear
// [R4] Falling edge, half bit, confirm start low
// [R5] High start centre: abandon silently, rewatch
// [R6] Full bit steps, majority vote, shift in
// [R7] Stop sample low sets framing error
// [R8] After stop push character, set pending
// [R9] Data read returns and removes oldest entry
// [R10] Pending equals enabled and FIFO not empty
// [R11] Interrupt needs all three enables set
// [R12] Framing status shows oldest entry's bit
// [R13] Port disable clears framing; receive disable not
// [R14] Framing error neither stops reception nor interrupts
// [R15] Third character into full FIFO sets overrun
// [R16] During overrun keep stored, accept nothing new
// [R17] Overrun clears only by receive/port disable
// [R18] Nine-bit mode; ninth field from oldest entry
// [R19] Address mode keeps only ninth-bit-set characters
// [R20] Software drops address mode before next stop
// [R21] Software reads status before data register
// [R22] Port disable holds the port in reset
// [R23] Nine-bit without address mode keeps all
// [R24] Majority from three samples around centre
`timescale 1ns/1ps
`default_nettype none

module async_serial_receiver (
	input wire logic i_ref_clk, // 40 MHz peripheral clock
	input wire logic i_sys_rst, // Async reset, active high
	input wire logic i_clk_en, // Freezes all state when low
	input wire logic i_baud_tick16, // One-cycle pulse at 16x baud
	input wire logic i_receive_line_pin, // Serial receive pin, async
	input wire logic i_port_enable_bit, // Serial port enable
	input wire logic i_receive_enable_bit, // Continuous receive enable
	input wire logic i_sync_select_bit, // Synchronous mode select
	input wire logic i_nine_bit_receive_select, // Nine-bit characters
	input wire logic i_address_detect_enable, // Keep only address chars
	input wire logic i_receive_interrupt_enable, // Receive interrupt enable
	input wire logic i_peripheral_interrupt_enable, // Peripheral group enable
	input wire logic i_global_interrupt_enable, // Global enable
	input wire logic i_data_read, // One-cycle read of data register
	output logic [rx_serial_pkg::DATA_W-1:0] o_receive_data_register, // Oldest data
	output logic o_ninth_bit_field, // Ninth bit of oldest entry
	output logic o_framing_error_status, // Framing bit of oldest entry
	output logic o_overrun_error_status, // Overrun flag
	output logic o_receive_pending_flag, // Unread character present
	output logic o_receive_interrupt // Gated receive interrupt
);
	import rx_serial_pkg::*;

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	localparam int CNT_W = $clog2(FIFO_DEPTH+1);

	logic line_meta;
	logic line_sync;
	logic line_prev;
	rx_state_t state;
	rx_state_t next_state;
	logic [TICK_W-1:0] tick_cnt;
	logic [1:0] early_samples;
	logic [BITCNT_W-1:0] bit_cnt;
	logic [CHAR_W-1:0] receive_shift_register;
	logic overrun_flag;
	wire rx_active;
	wire step;
	wire falling_edge;
	wire decide;
	wire majority;
	wire [BITCNT_W-1:0] last_bit;
	wire [DATA_W-1:0] char_data;
	wire char_ninth;
	wire stop_done;
	wire char_wanted;
	wire [ENTRY_W-1:0] new_entry;
	wire push_valid;
	wire fifo_ready;
	wire fifo_valid;
	wire [ENTRY_W-1:0] fifo_head;
	wire [CNT_W-1:0] fifo_count;
	wire pop_req;
	wire next_pending;

	// ----------------------------------------------------------------
	// Pin synchroniser
	// ----------------------------------------------------------------
	// Two flops before any logic; idle level keeps reset from faking an edge
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			line_meta <= LINE_IDLE;
			line_sync <= LINE_IDLE;
		end else if (i_clk_en) begin
			line_meta <= i_receive_line_pin;
			line_sync <= line_meta;
		end
	end

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	// Receiver runs only when port and receiver are on in async mode
	assign rx_active = i_port_enable_bit & i_receive_enable_bit & ~i_sync_select_bit; // R3
	assign step = i_clk_en & i_baud_tick16 & rx_active; // R1
	assign falling_edge = step & line_prev & ~line_sync; // R4
	assign decide = step & (tick_cnt == SAMPLE_LAST); // R24
	// Three samples at ticks 7, 8, 9 of each bit: tolerates one glitch
	assign majority = (early_samples[1] & early_samples[0]) |
		(early_samples[1] & line_sync) | (early_samples[0] & line_sync); // R24
	assign last_bit = i_nine_bit_receive_select ? LAST_BIT_9 : LAST_BIT_8; // R18
	// Eight-bit characters end one position high in the shifter
	assign char_data = i_nine_bit_receive_select ?
		receive_shift_register[DATA_W-1:0] : receive_shift_register[CHAR_W-1:1];
	assign char_ninth = i_nine_bit_receive_select & receive_shift_register[CHAR_W-1]; // R18
	assign stop_done = decide & (state == ST_STOP);
	// Address mode only matters with nine-bit characters
	assign char_wanted = ~(i_nine_bit_receive_select & i_address_detect_enable) |
		char_ninth; // R19 R23
	assign new_entry = {~majority, char_ninth, char_data}; // R7 R12
	assign push_valid = stop_done & char_wanted & ~overrun_flag; // R8 R16
	assign pop_req = i_clk_en & i_data_read; // R9
	assign next_pending = i_port_enable_bit & i_receive_enable_bit & fifo_valid; // R10

	// ----------------------------------------------------------------
	// Receive FIFO
	// ----------------------------------------------------------------
	// Flushed while the port is off, which also drops framing status
	rx_char_fifo #(
		.WIDTH(ENTRY_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.i_ref_clk(i_ref_clk),
		.i_sys_rst(i_sys_rst),
		.i_clk_en(i_clk_en),
		.i_clear(~i_port_enable_bit), // R22 R13
		.i_in_valid(push_valid), // R2
		.o_in_ready(fifo_ready),
		.i_in_data(new_entry),
		.o_out_valid(fifo_valid),
		.i_out_ready(pop_req), // R9
		.o_out_data(fifo_head),
		.o_count(fifo_count)
	);

	// ----------------------------------------------------------------
	// Character state machine
	// ----------------------------------------------------------------
	// A failed start check or a disable returns to edge watching
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (falling_edge) begin
					next_state = ST_START; // R4
				end
			end
			ST_START: begin
				if (decide) begin
					next_state = majority ? ST_IDLE : ST_DATA; // R5
				end
			end
			ST_DATA: begin
				if (decide && bit_cnt == last_bit) begin
					next_state = ST_STOP; // R6
				end
			end
			ST_STOP: begin
				if (decide) begin
					next_state = ST_IDLE; // R14
				end
			end
			default: next_state = ST_IDLE;
		endcase
		if (!rx_active) begin
			next_state = ST_IDLE; // R3
		end
	end

	// State, line history and oversample tick counter
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			state <= ST_IDLE;
			line_prev <= LINE_IDLE;
			tick_cnt <= TICK_START;
		end else if (i_clk_en) begin
			state <= next_state;
			if (!rx_active) begin
				line_prev <= LINE_IDLE;
			end else if (step) begin
				line_prev <= line_sync;
			end
			// Counter wraps every 16 ticks, one bit period per lap
			if (falling_edge && state == ST_IDLE) begin
				tick_cnt <= TICK_START; // R4
			end else if (step) begin
				tick_cnt <= tick_cnt + 1'b1; // R1
			end
		end
	end

	// Sample capture, bit count and shift register
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			early_samples <= '0;
			bit_cnt <= BITCNT_ZERO;
			receive_shift_register <= '0;
		end else if (i_clk_en) begin
			if (step && (tick_cnt == SAMPLE_FIRST || tick_cnt == SAMPLE_MID)) begin
				early_samples <= {early_samples[0], line_sync}; // R24
			end
			if (state == ST_START) begin
				bit_cnt <= BITCNT_ZERO;
			end else if (decide && state == ST_DATA) begin
				bit_cnt <= bit_cnt + 1'b1;
				receive_shift_register <= {majority,
					receive_shift_register[CHAR_W-1:1]}; // R6
			end
		end
	end

	// ----------------------------------------------------------------
	// Overrun
	// ----------------------------------------------------------------
	// Only software disabling clears it; while set nothing is stored
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			overrun_flag <= 1'b0;
		end else if (i_clk_en) begin
			if (!i_receive_enable_bit || !i_port_enable_bit) begin
				overrun_flag <= 1'b0; // R17
			end else if (push_valid && !fifo_ready) begin
				overrun_flag <= 1'b1; // R15
			end
		end
	end

	// ----------------------------------------------------------------
	// Registered outputs
	// ----------------------------------------------------------------
	// Status reflects the oldest entry; one cycle behind the FIFO
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_receive_data_register <= '0;
			o_ninth_bit_field <= 1'b0;
			o_framing_error_status <= 1'b0;
			o_overrun_error_status <= 1'b0;
			o_receive_pending_flag <= 1'b0;
			o_receive_interrupt <= 1'b0;
		end else if (i_clk_en) begin
			o_receive_data_register <= fifo_valid ? fifo_head[DATA_W-1:0] : '0; // R9
			o_ninth_bit_field <= fifo_valid & fifo_head[ENTRY_NINTH]; // R18
			o_framing_error_status <= fifo_valid & fifo_head[ENTRY_FRAMING_ERROR_STATUS]; // R12 R13
			o_overrun_error_status <= overrun_flag;
			o_receive_pending_flag <= next_pending; // R10
			// Framing errors never reach this gate directly
			o_receive_interrupt <= next_pending & i_receive_interrupt_enable &
				i_peripheral_interrupt_enable & i_global_interrupt_enable; // R11 R14
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	sequence s_stop_kept;
		stop_done && char_wanted && !overrun_flag;
	endsequence

	sequence s_start_rejected;
		decide && state == ST_START && majority;
	endsequence

	property p_inactive_idle;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		(i_clk_en && !rx_active) |=> (state == ST_IDLE);
	endproperty
	a_inactive_idle: assert property (p_inactive_idle) // R3
		else $error("receiver not idle while disabled");

	property p_false_start;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		(s_start_rejected and (rx_active && !pop_req)) |=>
			(state == ST_IDLE && $stable(fifo_count) && $stable(overrun_flag));
	endproperty
	a_false_start: assert property (p_false_start) // R5
		else $error("rejected start changed FIFO or state");

	property p_push_on_stop;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		(s_stop_kept and (fifo_ready && !pop_req && i_port_enable_bit)) |=>
			(fifo_count == $past(fifo_count) + 1'b1) ##1 o_receive_pending_flag;
	endproperty
	a_push_on_stop: assert property (p_push_on_stop) // R8
		else $error("character not stored or pending not raised after stop");

	property p_overrun_set;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		(s_stop_kept and (!fifo_ready && rx_active)) |=> overrun_flag ##1 o_overrun_error_status;
	endproperty
	a_overrun_set: assert property (p_overrun_set) // R15
		else $error("overrun not flagged on third character");

	property p_overrun_blocks;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		(overrun_flag && i_clk_en && !pop_req && i_port_enable_bit) |=>
			(fifo_count == $past(fifo_count));
	endproperty
	a_overrun_blocks: assert property (p_overrun_blocks) // R16
		else $error("FIFO changed during overrun");

	property p_overrun_clear;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		(i_clk_en && (!i_receive_enable_bit || !i_port_enable_bit)) |=> !overrun_flag;
	endproperty
	a_overrun_clear: assert property (p_overrun_clear) // R17
		else $error("overrun survived receiver disable");

	property p_overrun_sticky;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		(overrun_flag && i_receive_enable_bit && i_port_enable_bit) |=> overrun_flag;
	endproperty
	a_overrun_sticky: assert property (p_overrun_sticky) // R17
		else $error("overrun cleared while receiver enabled");

	property p_port_off_framing_error_status;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		(i_clk_en && !i_port_enable_bit) ##1 i_clk_en |=> !o_framing_error_status;
	endproperty
	a_port_off_framing_error_status: assert property (p_port_off_framing_error_status) // R13
		else $error("framing status not cleared by port disable");

	property p_address_discard;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		(stop_done && i_nine_bit_receive_select && i_address_detect_enable &&
			!char_ninth && !pop_req) |=> $stable(fifo_count);
	endproperty
	a_address_discard: assert property (p_address_discard) // R19
		else $error("non-address character stored in address mode");

	property p_irq_gate;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		o_receive_interrupt |-> o_receive_pending_flag &&
			$past(i_global_interrupt_enable && i_peripheral_interrupt_enable);
	endproperty
	a_irq_gate: assert property (p_irq_gate) // R11
		else $error("interrupt without pending flag or enables");

endmodule // async_serial_receiver

`default_nettype wire

// ---- src/rx_serial_pkg.sv ----
// Shared constants and types for the asynchronous serial receive path
package rx_serial_pkg;

	// ----------------------------------------------------------------
	// Oversampling and bit timing
	// ----------------------------------------------------------------
	localparam int OVERSAMPLE = 16;
	localparam int TICK_W = 4;
	localparam logic [TICK_W-1:0] TICK_START = 4'h0;
	localparam logic [TICK_W-1:0] SAMPLE_FIRST = 4'h7;
	localparam logic [TICK_W-1:0] SAMPLE_MID = 4'h8;
	localparam logic [TICK_W-1:0] SAMPLE_LAST = 4'h9;

	// ----------------------------------------------------------------
	// Character layout
	// ----------------------------------------------------------------
	localparam int DATA_W = 8;
	localparam int CHAR_W = 9;
	localparam int BITCNT_W = 4;
	localparam logic [BITCNT_W-1:0] BITCNT_ZERO = 4'h0;
	localparam logic [BITCNT_W-1:0] LAST_BIT_8 = 4'h7;
	localparam logic [BITCNT_W-1:0] LAST_BIT_9 = 4'h8;
	localparam logic LINE_IDLE = 1'b1;

	// ----------------------------------------------------------------
	// Receive FIFO entry: framing error, ninth bit, eight data bits
	// ----------------------------------------------------------------
	localparam int FIFO_DEPTH = 2;
	localparam int ENTRY_W = 10;
	localparam int ENTRY_NINTH = 8;
	localparam int ENTRY_FRAMING_ERROR_STATUS = 9;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_START,
		ST_DATA,
		ST_STOP
	} rx_state_t;

endpackage

// ---- src/rx_char_fifo.sv ----
// Parameterised character FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module rx_char_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 2
) (
	input wire logic i_ref_clk, // Peripheral clock
	input wire logic i_sys_rst, // Async reset, active high
	input wire logic i_clk_en, // Freezes all state when low
	input wire logic i_clear, // Synchronous flush
	input wire logic i_in_valid, // Write side offers an entry
	output logic o_in_ready, // Room for one more entry
	input wire logic [WIDTH-1:0] i_in_data, // Entry to store
	output logic o_out_valid, // Oldest entry present
	input wire logic i_out_ready, // Reader takes the oldest entry
	output logic [WIDTH-1:0] o_out_data, // Oldest entry
	output logic [$clog2(DEPTH+1)-1:0] o_count // Entries held
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH+1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic [CW-1:0] count;
	wire push;
	wire pop;
	wire [PW-1:0] next_wr_ptr;
	wire [PW-1:0] next_rd_ptr;

	// Handshakes and pointer wrap; full/empty come from the count alone
	assign o_in_ready = (count != CW'(DEPTH));
	assign o_out_valid = (count != '0);
	assign push = i_in_valid & o_in_ready;
	assign pop = o_out_valid & i_out_ready;
	assign next_wr_ptr = (wr_ptr == PW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
	assign next_rd_ptr = (rd_ptr == PW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
	assign o_out_data = mem[rd_ptr];
	assign o_count = count;

	// Storage has no reset; count guards every read of it
	always_ff @(posedge i_ref_clk) begin
		if (i_clk_en && push && !i_clear) begin
			mem[wr_ptr] <= i_in_data;
		end
	end

	// Pointers and occupancy
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else if (i_clk_en) begin
			if (i_clear) begin
				wr_ptr <= '0;
				rd_ptr <= '0;
				count <= '0;
			end else begin
				if (push) begin
					wr_ptr <= next_wr_ptr;
				end
				if (pop) begin
					rd_ptr <= next_rd_ptr;
				end
				case ({push, pop})
					2'b10: count <= count + 1'b1;
					2'b01: count <= count - 1'b1;
					default: count <= count;
				endcase
			end
		end
	end

endmodule // rx_char_fifo

`default_nettype wire

// ---- test/serial_tx_model.sv ----
// Remote asynchronous transmitter model driving the receive line
`timescale 1ns/1ps
`default_nettype none

module serial_tx_model (
	input wire logic i_ref_clk, // Bench clock
	input wire logic i_baud_tick16, // Sixteen ticks per bit
	output logic o_line // Serial line, idle high
);
	// --------------------
	// Line shaping
	// --------------------
	// Idle level is high, so a released line rests there
	initial o_line = 1'b1;

	// Drive a level for n ticks, then step off the edge
	task automatic put(input logic lvl, input int n);
		o_line = lvl;
		repeat (n) begin
			@(posedge i_ref_clk);
			while (i_baud_tick16 !== 1'b1) @(posedge i_ref_clk);
		end
		#2;
	endtask

	// One frame, LSB first; spike flips one tick near each data centre
	task automatic send(input logic [8:0] ch, input logic nine, input logic stop,
		input logic spike);
		put(1'b0, 16);
		for (int b = 0; b < 9; b++) begin
			if (b < 8 || nine) begin
				if (spike) begin
					put(ch[b], 8);
					put(~ch[b], 1);
					put(ch[b], 7);
				end else begin
					put(ch[b], 16);
				end
			end
		end
		put(stop, 16);
		// A low stop needs the line high again before the next start
		if (!stop) put(1'b1, 16);
	endtask

	// Short low pulse that is gone by the start-bit centre
	task automatic glitch();
		put(1'b0, 4);
		put(1'b1, 16);
	endtask
endmodule // serial_tx_model

`default_nettype wire

// ---- test/tb_top.sv ----
// Self-checking testbench for the asynchronous serial receive path
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	import rx_serial_pkg::*;

	// --------------------
	// Signals and bookkeeping
	// --------------------
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic clk_en = 1'b1;
	logic tick = 1'b0;
	logic [1:0] tdiv = 2'h0;
	wire logic line;
	logic port_en = 1'b1;
	logic rx_en = 1'b1;
	logic sync_sel = 1'b0;
	logic nine_sel = 1'b0;
	logic addr_en = 1'b0;
	logic [2:0] ien = 3'h7;
	logic rd = 1'b0;
	logic auto_rd = 1'b1;
	logic [DATA_W-1:0] rdata;
	logic ninth, framing_error_status, overrun_error_status, pend, irq;
	logic [9:0] exp_q[$];
	logic [9:0] exp_v;
	int fail_count = 0;
	int total_checks = 0;

	always #12.5 clk = ~clk;

	// Tick every fourth clock keeps a frame short
	always @(posedge clk) begin
		#2;
		tdiv = tdiv + 2'h1;
		tick = (tdiv == 2'h0);
	end

	async_serial_receiver async_serial_receiver_inst (
		.i_ref_clk(clk), .i_sys_rst(rst), .i_clk_en(clk_en), .i_baud_tick16(tick),
		.i_receive_line_pin(line), .i_port_enable_bit(port_en),
		.i_receive_enable_bit(rx_en), .i_sync_select_bit(sync_sel),
		.i_nine_bit_receive_select(nine_sel), .i_address_detect_enable(addr_en),
		.i_receive_interrupt_enable(ien[0]), .i_peripheral_interrupt_enable(ien[1]),
		.i_global_interrupt_enable(ien[2]), .i_data_read(rd),
		.o_receive_data_register(rdata), .o_ninth_bit_field(ninth),
		.o_framing_error_status(framing_error_status), .o_overrun_error_status(overrun_error_status),
		.o_receive_pending_flag(pend), .o_receive_interrupt(irq)
	);

	serial_tx_model serial_tx_model_inst (.i_ref_clk(clk), .i_baud_tick16(tick),
		.o_line(line));

	// --------------------
	// Compare and helper tasks
	// --------------------
	task automatic check_char(input logic [9:0] got, input logic [9:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check_bit(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask

	// Note the expected entry, then let the far side send it
	task automatic xmit(input logic [8:0] ch, input logic stop, input logic keep);
		logic sp;
		sp = 1'($urandom_range(1, 0));
		if (keep && !(addr_en && nine_sel && !ch[8]))
			exp_q.push_back({~stop, nine_sel & ch[8], ch[7:0]});
		serial_tx_model_inst.send(ch, nine_sel, stop, sp);
	endtask

	// Bounded wait for every noted character to be read back
	task automatic drain();
		int n;
		n = 0;
		while (exp_q.size() != 0 && n < 3000) begin
			@(posedge clk);
			n++;
		end
		// A character that never shows up within the limit is a mismatch
		if (exp_q.size() != 0) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, exp_q.size(), 0);
		end
		idle(6);
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// --------------------
	// Reader: status first, then the data read that pops the entry
	// --------------------
	initial begin
		forever begin
			@(posedge clk);
			#2;
			if (auto_rd && pend === 1'b1) begin
				exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 10'bx;
				check_char({framing_error_status, ninth, rdata}, exp_v);
				rd = 1'b1;
				@(posedge clk);
				#2;
				rd = 1'b0;
				// Outputs lag the pop by one clock
				@(posedge clk);
			end
		end
	end

	// Watchdog sized well beyond the expected run
	initial begin
		repeat (70000) @(posedge clk);
		fail_count++;
		$display("mismatch at %0t: got %h expected %h", $time, 1'b0, 1'b1);
		end_of_test();
	end

	// --------------------
	// Main sequence
	// --------------------
	initial begin
		void'($urandom(32'hAA80862D));
		idle(12);
		rst = 1'b0;
		idle(4);
		// Random characters back to back
		for (int i = 0; i < 5; i++) xmit(9'($urandom), 1'b1, 1'b1);
		drain();
		check_char(10'(exp_q.size()), 10'h000);
		$display("test 1 done");
		// Framing error held with its entry; gating of the interrupt
		auto_rd = 1'b0;
		xmit(9'h0A5, 1'b0, 1'b1);
		idle(4);
		check_bit(pend, 1'b1);
		check_bit(framing_error_status, 1'b1);
		for (int k = 0; k < 3; k++) begin
			ien = 3'h7 ^ (3'h1 << k);
			idle(3);
			check_bit(irq, 1'b0);
			check_bit(pend, 1'b1);
		end
		ien = 3'h7;
		idle(3);
		check_bit(irq, 1'b1);
		xmit(9'h05A, 1'b1, 1'b1);
		auto_rd = 1'b1;
		drain();
		check_bit(irq, 1'b0);
		$display("test 2 done");
		// Start pulse too short is dropped without error
		serial_tx_model_inst.glitch();
		xmit(9'h0C3, 1'b1, 1'b1);
		drain();
		check_bit(framing_error_status, 1'b0);
		$display("test 3 done");
		// Overrun: third character lost, stored ones survive
		auto_rd = 1'b0;
		xmit(9'h011, 1'b1, 1'b1);
		xmit(9'h022, 1'b1, 1'b1);
		xmit(9'h033, 1'b1, 1'b0);
		idle(4);
		check_bit(overrun_error_status, 1'b1);
		xmit(9'h044, 1'b1, 1'b0);
		auto_rd = 1'b1;
		drain();
		check_bit(pend, 1'b0);
		check_bit(overrun_error_status, 1'b1);
		// Clock enable low freezes the flag even though the receiver is off
		clk_en = 1'b0;
		rx_en = 1'b0;
		idle(4);
		check_bit(overrun_error_status, 1'b1);
		clk_en = 1'b1;
		idle(4);
		check_bit(overrun_error_status, 1'b0);
		rx_en = 1'b1;
		idle(4);
		xmit(9'h055, 1'b1, 1'b1);
		drain();
		$display("test 4 done");
		// Nine-bit characters, then address filtering
		nine_sel = 1'b1;
		xmit(9'h1E7, 1'b1, 1'b1);
		xmit(9'h018, 1'b1, 1'b1);
		drain();
		addr_en = 1'b1;
		xmit(9'h066, 1'b1, 1'b1);
		xmit(9'h1A3, 1'b1, 1'b1);
		drain();
		// Address matched: software leaves address mode
		addr_en = 1'b0;
		xmit(9'h03C, 1'b1, 1'b1);
		drain();
		nine_sel = 1'b0;
		$display("test 5 done");
		// Receive and port disables, synchronous select
		auto_rd = 1'b0;
		xmit(9'h099, 1'b0, 1'b1);
		idle(4);
		rx_en = 1'b0;
		idle(4);
		check_bit(framing_error_status, 1'b1);
		check_bit(pend, 1'b0);
		rx_en = 1'b1;
		idle(4);
		check_bit(pend, 1'b1);
		port_en = 1'b0;
		idle(4);
		check_bit(framing_error_status, 1'b0);
		check_bit(pend, 1'b0);
		exp_q.delete();
		port_en = 1'b1;
		sync_sel = 1'b1;
		xmit(9'h0F0, 1'b1, 1'b0);
		idle(4);
		check_bit(pend, 1'b0);
		sync_sel = 1'b0;
		rx_en = 1'b0;
		xmit(9'h00F, 1'b1, 1'b0);
		idle(4);
		check_bit(pend, 1'b0);
		rx_en = 1'b1;
		auto_rd = 1'b1;
		idle(4);
		xmit(9'h081, 1'b1, 1'b1);
		drain();
		check_char(10'(exp_q.size()), 10'h000);
		$display("test 6 done");
		end_of_test();
	end
endmodule // tb_top

`default_nettype wire
